// File: hdl/imc_cfg.svh
// Constants of the two-wire mode-control block
// Assumes inclusion by bare name from the top module and the bench
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH
`define IMC_OFF_MODE   8'h00
`define IMC_OFF_OWN    8'h04
`define IMC_OFF_TARGET 8'h08
`define IMC_OFF_COUNT  8'h0C
`define IMC_OFF_TXD    8'h10
`define IMC_OFF_RXD    8'h14
`define IMC_OFF_STAT   8'h18
`define IMC_MODE_RST   16'h0000
`define IMC_MODE_WMASK 16'hEFFF
`define IMC_B_START    13
`define IMC_B_STOP     11
`define IMC_B_MASTER   10
`define IMC_B_DIR      9
`define IMC_B_WIDE     8
`define IMC_B_REPEAT   7
`define IMC_B_LOOP     6
`define IMC_B_ENABLE   5
`define IMC_S_BUSY     0
`define IMC_S_RXRDY    1
`define IMC_S_STOPSEEN 2
`define IMC_S_MASTER   3
`define IMC_PSC_RATIO  4
`define IMC_ADDR10_HDR 5'h1E
`endif

// File: hdl/imc_pkg.sv
// Types of the two-wire mode-control block
// Needs nothing from the constants header
package imc_pkg;
  // Sequencer states, Gray along idle-start-address-data-stop
  typedef enum logic [2:0] {
    IMC_IDLE  = 3'h0,
    IMC_START = 3'h1,
    IMC_ADDR  = 3'h3,
    IMC_DATA  = 3'h2,
    IMC_STOP  = 3'h6
  } imc_state_t;
endpackage : imc_pkg

// File: hdl/imc_mode_ctrl.sv
// Mode control and word sequencer of a two-wire bus controller
// Assumes one 10 MHz clock, a plain register port, and the pad wire-AND
// Behaviour
// - Master stops when counter reaches zero, stop set
// - Stop request self-clears after the stop
// - Master role self-clears on generated stop
// - Master drives clock; slave leaves clock alone
// - Direction bit picks receive or transmit
// - Seven-bit target and own address when narrow
// - Ten-bit target and own address when expanded
// - Counted mode moves exactly the count
// - Repeat mode runs until stop requested
// - Repeat bit ignored unless master transmitter
// - Stop request ends repeat mode; start request inserts a repeated START
// - Loopback returns each word after n cycles
// - Loopback shares one clock, sends own address
// - Enable low holds reset, clears status
// - Start request makes START when master, then self-clears
//
// Chosen here: the register offsets and the address-and-strobe port.
`include "imc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module imc_mode_ctrl #(
  parameter int RATIO = `IMC_PSC_RATIO  // Module clocks per bit time
) (
  input  wire logic       MCLK_IN,
  input  wire logic       ARST_N_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic [31:0]     REG_RDATA_OUT,
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE_OUT,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_OUT
);
  localparam int HALF = RATIO / 2;  // Clock rises mid bit
  localparam int LOOP_N = RATIO * 8;  // Loopback latency per word

  // Address byte builder, used for both halves of a wide address
  function automatic logic [7:0] addr_byte(input logic first, input logic wide,
                                           input logic [9:0] a, input logic rd);
    if (!wide) addr_byte = {a[6:0], rd};
    else if (first) addr_byte = {`IMC_ADDR10_HDR, a[9:8], rd};
    else addr_byte = a[7:0];
  endfunction : addr_byte

  imc_pkg::imc_state_t st_r;          // Sequencer state
  logic [15:0] mode_r;                // Mode control register
  logic [9:0]  own_r;                 // Own address
  logic [9:0]  tgt_r;                 // Target address
  logic [15:0] cnt_r;                 // Word count setting
  logic [15:0] wcnt_r;                // Internal down counter
  logic [7:0]  txd_r;                 // Transmit data
  logic [7:0]  rxd_r;                 // Receive data
  logic [7:0]  sh_r;                  // Transmit shifter
  logic [7:0]  rsh_r;                 // Receive shifter
  logic [2:0]  bit_r;                 // Bit within word
  logic [7:0]  ph_r;                  // Phase within bit
  logic        second_r;              // Second address byte pending
  logic        rxrdy_r;               // Word received, unread
  logic        stopseen_r;            // Sticky stop seen
  logic [1:0]  scl_sy_r;              // Clock pin synchroniser
  logic [1:0]  sda_sy_r;              // Data pin synchroniser
  logic [31:0] rdata_r;               // Read data stage

  // Named mode fields
  wire en      = mode_r[`IMC_B_ENABLE];
  wire master  = mode_r[`IMC_B_MASTER];
  wire dir_tx  = mode_r[`IMC_B_DIR];
  wire wide    = mode_r[`IMC_B_WIDE];
  wire loop    = mode_r[`IMC_B_LOOP];
  wire stop_rq = mode_r[`IMC_B_STOP];
  wire start_rq = mode_r[`IMC_B_START];
  // Repeat counts only for a master transmitter
  wire rep     = mode_r[`IMC_B_REPEAT] & master & dir_tx;
  // Loopback sends own address instead of the target
  wire [9:0] dest = loop ? own_r : tgt_r;

  // Bus decode
  wire wr_mode = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_MODE;
  wire wr_own  = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_OWN;
  wire wr_tgt  = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_TARGET;
  wire wr_cnt  = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_COUNT;
  wire wr_txd  = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_TXD;
  wire wr_stat = REG_WR_IN && REG_ADDR_IN == `IMC_OFF_STAT;
  wire rd_rxd  = REG_RD_IN && REG_ADDR_IN == `IMC_OFF_RXD;

  // Bit timing: one tick ends each bit time
  wire active  = st_r != imc_pkg::IMC_IDLE;
  wire tick    = active && ph_r == 8'(RATIO - 1);
  wire sample  = active && ph_r == 8'(HALF);
  wire low_ph  = ph_r < 8'(HALF);
  // STOP keeps data low until the clock is back high
  wire stop_low = ph_r < 8'(RATIO - 1);
  wire last_b  = tick && bit_r == 3'h7;
  // Loopback takes the shifter, one clock for both ways
  wire in_bit  = loop ? sh_r[7] : sda_sy_r[1];
  wire word_end = last_b && st_r == imc_pkg::IMC_DATA;
  wire addr_end = last_b && st_r == imc_pkg::IMC_ADDR && !second_r;
  wire [15:0] wcnt_dec = wcnt_r - 16'h0001;
  // Counter after this word, frozen in repeat mode
  wire [15:0] wcnt_nx = rep ? wcnt_r : wcnt_dec;
  // Counted transfer ends at zero
  wire cnt_done = !rep && (addr_end ? cnt_r == 16'h0000 : wcnt_nx == 16'h0000);
  wire go_stop = stop_rq && (rep || cnt_done);
  wire hw_start_clr = st_r == imc_pkg::IMC_START && tick;
  wire hw_stop_done = st_r == imc_pkg::IMC_STOP && tick;

  imc_pkg::imc_state_t st_nxt;
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      imc_pkg::IMC_IDLE:
        if (en && master && start_rq) st_nxt = imc_pkg::IMC_START;
      imc_pkg::IMC_START:
        if (tick) st_nxt = imc_pkg::IMC_ADDR;
      imc_pkg::IMC_ADDR:
        if (addr_end) begin
          if (go_stop) st_nxt = imc_pkg::IMC_STOP;
          else if (cnt_done) st_nxt = imc_pkg::IMC_IDLE;
          else st_nxt = imc_pkg::IMC_DATA;
        end
      imc_pkg::IMC_DATA:
        if (word_end) begin
          if (start_rq) st_nxt = imc_pkg::IMC_START;  // Repeated start
          else if (go_stop) st_nxt = imc_pkg::IMC_STOP;
          else if (cnt_done) st_nxt = imc_pkg::IMC_IDLE;
        end
      imc_pkg::IMC_STOP:
        if (tick) st_nxt = imc_pkg::IMC_IDLE;
      default: st_nxt = imc_pkg::IMC_IDLE;
    endcase
  end

  // State register; disable forces idle
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) st_r <= imc_pkg::IMC_IDLE;
    else if (!en) st_r <= imc_pkg::IMC_IDLE;
    else st_r <= st_nxt;
  end

  // Mode register; a software write beats the self-clears
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_r <= `IMC_MODE_RST;
    end else if (wr_mode) begin
      mode_r <= REG_WDATA_IN[15:0] & `IMC_MODE_WMASK;
    end else begin
      if (hw_start_clr) mode_r[`IMC_B_START] <= 1'b0;
      if (hw_stop_done) begin
        mode_r[`IMC_B_STOP] <= 1'b0;
        mode_r[`IMC_B_MASTER] <= 1'b0;  // Back to slave
      end
    end
  end

  // Plain setting registers
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      own_r <= 10'h000;
      tgt_r <= 10'h000;
      cnt_r <= 16'h0000;
      txd_r <= 8'h00;
    end else begin
      if (wr_own) own_r <= REG_WDATA_IN[9:0];
      if (wr_tgt) tgt_r <= REG_WDATA_IN[9:0];
      if (wr_cnt) cnt_r <= REG_WDATA_IN[15:0];
      if (wr_txd) txd_r <= REG_WDATA_IN[7:0];
    end
  end

  // Bit phase and bit counters
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ph_r <= 8'h00;
      bit_r <= 3'h0;
    end else if (!active || !en) begin
      ph_r <= 8'h00;
      bit_r <= 3'h0;
    end else if (tick) begin
      ph_r <= 8'h00;
      // Start and stop are single bit times
      if (st_r == imc_pkg::IMC_ADDR || st_r == imc_pkg::IMC_DATA) bit_r <= bit_r + 3'h1;
      else bit_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 8'h01;
    end
  end

  // Shifters and word counter
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sh_r <= 8'h00;
      rsh_r <= 8'h00;
      wcnt_r <= 16'h0000;
      second_r <= 1'b0;
    end else if (hw_start_clr) begin
      // Width of address follows the expanded bit
      sh_r <= addr_byte(1'b1, wide, dest, ~dir_tx);
      second_r <= wide;
      wcnt_r <= cnt_r;
    end else begin
      if (sample) rsh_r <= {rsh_r[6:0], in_bit};
      if (last_b && st_r == imc_pkg::IMC_ADDR && second_r) begin
        sh_r <= addr_byte(1'b0, wide, dest, ~dir_tx);
        second_r <= 1'b0;
      end else if (addr_end || word_end) begin
        sh_r <= txd_r;
        if (word_end) wcnt_r <= wcnt_nx;
      end else if (tick) begin
        sh_r <= {sh_r[6:0], 1'b0};
      end
    end
  end

  // Status flags; hardware set wins over the clear, disable clears
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rxd_r <= 8'h00;
      rxrdy_r <= 1'b0;
      stopseen_r <= 1'b0;
    end else if (!en) begin
      rxrdy_r <= 1'b0;
      stopseen_r <= 1'b0;
    end else begin
      // Received word lands in the receive register
      if (word_end && (!dir_tx || loop)) begin
        rxd_r <= rsh_r;
        rxrdy_r <= 1'b1;
      end else if (rd_rxd) begin
        rxrdy_r <= 1'b0;
      end
      if (hw_stop_done) stopseen_r <= 1'b1;
      else if (wr_stat && REG_WDATA_IN[`IMC_S_STOPSEEN]) stopseen_r <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
    end else begin
      scl_sy_r <= {scl_sy_r[0], SCL_IN};
      sda_sy_r <= {sda_sy_r[0], SDA_IN};
    end
  end
  // A clock pulled low must read low on the pin two cycles on
  scl_pulled_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    $past(SCL_OE_OUT, 2) |-> !scl_sy_r[1]) else $error("clock pull not seen on pin");

  // Read data select, stands one cycle after the strobe
  wire [31:0] stat_w = {28'h0, master, stopseen_r, rxrdy_r, active};
  wire [31:0] rsel =
      REG_ADDR_IN == `IMC_OFF_MODE   ? {16'h0, mode_r} :
      REG_ADDR_IN == `IMC_OFF_OWN    ? {22'h0, own_r} :
      REG_ADDR_IN == `IMC_OFF_TARGET ? {22'h0, tgt_r} :
      REG_ADDR_IN == `IMC_OFF_COUNT  ? {16'h0, cnt_r} :
      REG_ADDR_IN == `IMC_OFF_TXD    ? {24'h0, txd_r} :
      REG_ADDR_IN == `IMC_OFF_RXD    ? {24'h0, rxd_r} :
      REG_ADDR_IN == `IMC_OFF_STAT   ? stat_w : 32'h0000_0000;

  // Read stage, zero outside a read
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) rdata_r <= 32'h0000_0000;
    else rdata_r <= REG_RD_IN ? rsel : 32'h0000_0000;
  end
  assign REG_RDATA_OUT = rdata_r;

  // Pins: open drain, only pulled low; slave never drives clock
  wire drv_bits = st_r == imc_pkg::IMC_ADDR ||
                  (st_r == imc_pkg::IMC_DATA && dir_tx);
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  // Clock low at STOP entry so data falls while the clock is low, no false START
  assign SCL_OE_OUT = master && en && low_ph &&
                      (st_r == imc_pkg::IMC_ADDR || st_r == imc_pkg::IMC_DATA ||
                       st_r == imc_pkg::IMC_STOP);
  assign SDA_OE_OUT = st_r == imc_pkg::IMC_START ||
                      (st_r == imc_pkg::IMC_STOP && stop_low) ||
                      (drv_bits && !sh_r[7]);

  // Checks
  scl_slave_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !master |-> !SCL_OE_OUT) else $error("clock driven while slave");
  stop_clears_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    hw_stop_done && !wr_mode |=> !stop_rq) else $error("stop request kept");
  master_drop_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    hw_stop_done && !wr_mode |=> !master && st_r == imc_pkg::IMC_IDLE)
    else $error("master role kept after stop");
  start_clears_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    $rose(st_r == imc_pkg::IMC_START) |-> ##[1:8] !start_rq || wr_mode)
    else $error("start request not cleared");
  stop_at_zero_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    word_end && stop_rq && !rep && wcnt_r == 16'h0001 && !start_rq && en
    |=> st_r == imc_pkg::IMC_STOP) else $error("no stop at count zero");
  count_dec_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    word_end && !rep && !hw_start_clr |=> wcnt_r == $past(wcnt_r) - 16'h0001)
    else $error("counter did not step");
  repeat_hold_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    word_end && rep && !stop_rq && !start_rq && en |=> st_r == imc_pkg::IMC_DATA)
    else $error("repeat transfer ended early");
  loop_return_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    word_end && loop && en |=> rxd_r == $past(rsh_r) && rxrdy_r)
    else $error("loopback word not returned");
  disable_clr_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !en |=> !rxrdy_r && !stopseen_r && st_r == imc_pkg::IMC_IDLE)
    else $error("status kept while disabled");
  addr_width_a: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    hw_start_clr && !wide |=> sh_r == {$past(dest[6:0]), ~$past(dir_tx)})
    else $error("narrow address wrong");
endmodule : imc_mode_ctrl
`default_nettype wire

// File: verification/imc_bus_peer.sv
// Remote two-wire slave model facing the mode-control block
// Assumes the bench builds wired levels with pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module imc_bus_peer (
  input  wire logic       scl,       // Wired clock level
  input  wire logic       sda,       // Wired data level
  input  wire logic       reply_en,  // Answer a read transfer
  input  wire logic [7:0] reply,     // Word sent back, MSB first
  output logic            sda_oe,    // High pulls data low
  output int              n_bits,    // Bits since the last START
  output logic [15:0]     shreg,     // Last sixteen bits seen
  output int              n_stop     // STOP conditions seen
);
  logic pend;    // A sampled bit not yet closed by a falling clock
  logic pend_v;  // Level of that bit
  initial begin
    sda_oe = 1'b0;
    n_bits = 0;
    shreg  = 16'h0000;
    n_stop = 0;
    pend   = 1'b0;
    pend_v = 1'b0;
  end
  // START: data falls while clock high; settle first so a shared edge is no START
  always @(negedge sda) begin
    #1;
    if (scl && !sda) begin
      n_bits = 0;
      pend   = 1'b0;
    end
  end
  // STOP: data rises while clock high; the clock rise of a STOP is no bit
  always @(posedge sda) begin
    #1;
    if (scl) begin
      n_stop = n_stop + 1;
      pend   = 1'b0;
    end
  end
  // Clock comes from the master only; sample on its rise
  always @(posedge scl) begin
    pend_v = sda;
    pend   = 1'b1;
  end
  // Falling clock closes a bit; reply bits change only while the clock is low
  always @(negedge scl) begin
    if (pend) begin
      shreg  = {shreg[14:0], pend_v};
      n_bits = n_bits + 1;
      pend   = 1'b0;
    end
    if (reply_en && n_bits >= 8 && n_bits < 16) sda_oe = !reply[15 - n_bits];
    else sda_oe = 1'b0;
  end
endmodule : imc_bus_peer
`default_nettype wire

// File: verification/imc_mode_ctrl_test.sv
// Self-checking bench of the two-wire mode-control block
// Assumes the design header beside the design; one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "imc_cfg.svh"
module imc_mode_ctrl_test;
  localparam int          RATIO = 4;  // Short bit time keeps runs brief
  localparam logic [31:0] EN  = 32'h1 << `IMC_B_ENABLE;
  localparam logic [31:0] MAS    = 32'h1 << `IMC_B_MASTER;
  localparam logic [31:0] DIR    = 32'h1 << `IMC_B_DIR;
  localparam logic [31:0] WIDE   = 32'h1 << `IMC_B_WIDE;
  localparam logic [31:0] RPT    = 32'h1 << `IMC_B_REPEAT;
  localparam logic [31:0] LPB    = 32'h1 << `IMC_B_LOOP;
  localparam logic [31:0] STOPQ  = 32'h1 << `IMC_B_STOP;
  localparam logic [31:0] STARTQ = 32'h1 << `IMC_B_START;
  logic        mclk = 1'b0;           // Module clock
  logic        arst_n = 1'b0;         // Reset, low active
  logic [7:0]  reg_addr = 8'h00;      // Register address
  logic [31:0] reg_wdata = 32'h0;     // Write data
  logic        reg_wr = 1'b0;         // Write strobe
  logic        reg_rd = 1'b0;         // Read strobe
  logic        reply_en = 1'b0;       // Peer answers reads
  logic [31:0] reg_rdata;             // Read data
  logic        scl_oe;                // Design pulls clock low
  logic        sda_oe;                // Design pulls data low
  logic        peer_oe;               // Peer pulls data low
  logic [15:0] peer_sh;               // Bits the peer captured
  int          peer_bits;             // Bit count since START
  int          peer_stops;            // STOPs on the wire
  int          n_mismatch = 0;        // Failed comparisons
  int          n_checks = 0;          // All comparisons
  int          cyc = 0;               // Cycle count for the hang guard
  // Wire-AND with pull-ups on both lines
  wire logic   scl = !scl_oe;
  wire logic   sda = !(sda_oe | peer_oe);
  imc_mode_ctrl #(.RATIO(RATIO)) u_imc_mode_ctrl (
    .MCLK_IN(mclk), .ARST_N_IN(arst_n), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(reg_rdata), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe));
  imc_bus_peer u_imc_bus_peer (
    .scl(scl), .sda(sda), .reply_en(reply_en), .reply(8'hA5), .sda_oe(peer_oe),
    .n_bits(peer_bits), .shreg(peer_sh), .n_stop(peer_stops));
  // Clock of 100 ns period
  initial begin
    forever #50 mclk = !mclk;
  end
  // Hang guard: whole run is far below this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_chk
  // Poll busy with a bound; a stuck transfer counts as a mismatch
  task automatic wait_idle;
    logic [31:0] s;
    int          i;
    i = 0;
    repeat (3) @(posedge mclk);
    s = 32'h1;
    while (s[`IMC_S_BUSY] !== 1'b0 && i < 3000) begin
      rd(`IMC_OFF_STAT, s);
      i++;
    end
    check(32'(i < 3000), 32'h1);
  endtask : wait_idle
  task automatic t_reset;
    rd_chk(`IMC_OFF_MODE, 32'h0);
    rd_chk(`IMC_OFF_STAT, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);       // Unmapped place ignores writes
    rd_chk(8'h40, 32'h0);
    wr(`IMC_OFF_MODE, 32'hFFFF1000);
    rd_chk(`IMC_OFF_MODE, 32'h0);
  endtask : t_reset
  task automatic t_counted;
    int s0;
    s0 = peer_stops;
    wr(`IMC_OFF_TARGET, 32'h52);
    wr(`IMC_OFF_COUNT, 32'h2);
    wr(`IMC_OFF_TXD, 32'hC3);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | STOPQ | STARTQ);
    wait_idle();
    check(32'(peer_bits), 32'h18);
    check(32'(peer_sh), 32'hC3C3);
    check(32'(peer_stops - s0), 32'h1);
    rd_chk(`IMC_OFF_MODE, EN | DIR);
    rd_chk(`IMC_OFF_STAT, 32'h4);
    wr(`IMC_OFF_STAT, 32'h4);
  endtask : t_counted
  task automatic t_ten;
    wr(`IMC_OFF_TARGET, 32'h2B7);
    wr(`IMC_OFF_COUNT, 32'h0);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | WIDE | STOPQ | STARTQ);
    wait_idle();
    check(32'(peer_bits), 32'h10);
    check(32'(peer_sh), 32'({5'(`IMC_ADDR10_HDR), 2'b10, 1'b0, 8'hB7}));
    rd_chk(`IMC_OFF_MODE, EN | DIR | WIDE);
    wr(`IMC_OFF_STAT, 32'h4);
  endtask : t_ten
  task automatic t_rx;
    reply_en <= 1'b1;
    wr(`IMC_OFF_TARGET, 32'h2D);
    wr(`IMC_OFF_COUNT, 32'h1);
    wr(`IMC_OFF_MODE, EN | MAS | STOPQ | STARTQ);
    wait_idle();
    check(32'(peer_sh[15:8]), 32'h5B);
    rd_chk(`IMC_OFF_STAT, 32'h6);
    rd_chk(`IMC_OFF_RXD, 32'hA5);
    rd_chk(`IMC_OFF_STAT, 32'h4);
    reply_en <= 1'b0;
    wr(`IMC_OFF_STAT, 32'h4);
  endtask : t_rx
  task automatic t_repeat;
    int i;
    wr(`IMC_OFF_COUNT, 32'h1);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | RPT | STARTQ);
    for (i = 0; i < 3000 && peer_bits < 32; i++) @(posedge mclk);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | RPT | STOPQ);
    wait_idle();
    check(32'(peer_bits % 8), 32'h0);
    check(32'(peer_bits >= 40), 32'h1);
    rd_chk(`IMC_OFF_MODE, EN | DIR | RPT);
    wr(`IMC_OFF_STAT, 32'h4);
  endtask : t_repeat
  task automatic t_slave;
    logic any;
    any = 1'b0;
    wr(`IMC_OFF_MODE, EN | DIR | RPT | STARTQ);
    repeat (60) begin
      @(posedge mclk);
      any = any | scl_oe | sda_oe;
    end
    check(32'(any), 32'h0);
    wr(`IMC_OFF_MODE, 32'h0);
  endtask : t_slave
  task automatic t_loop;
    wr(`IMC_OFF_OWN, 32'h33);
    wr(`IMC_OFF_COUNT, 32'h1);
    wr(`IMC_OFF_TXD, 32'h3C);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | LPB | STOPQ | STARTQ);  // Free format stays clear
    wait_idle();
    check(32'(peer_sh[15:8]), 32'h66);
    rd_chk(`IMC_OFF_RXD, 32'h3C);
  endtask : t_loop
  task automatic t_disable;
    wr(`IMC_OFF_MODE, EN | MAS | DIR | RPT | STARTQ);
    repeat (40) @(posedge mclk);
    wr(`IMC_OFF_MODE, EN | MAS | DIR | RPT | STOPQ);  // Let the word end first
    wait_idle();
    rd_chk(`IMC_OFF_STAT, 32'h4);
    wr(`IMC_OFF_MODE, 32'h0);  // Disabled only while idle
    #1;
    check(32'({scl_oe, sda_oe}), 32'h0);
    rd_chk(`IMC_OFF_STAT, 32'h0);
    rd_chk(`IMC_OFF_MODE, 32'h0);
  endtask : t_disable
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_counted();
    t_ten();
    t_rx();
    t_repeat();
    t_slave();
    t_loop();
    t_disable();
    finish_test();
  end
endmodule : imc_mode_ctrl_test
`default_nettype wire
